// ===== common/hsc_params.svh
// hsc_params.svh: register offsets, field positions and reset values
// for the high-speed counter channel; assumes a byte-addressed APB map
`ifndef HSC_PARAMS_SVH
`define HSC_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define HSC_OFS_CTRL 8'h00
`define HSC_OFS_MODE 8'h04
`define HSC_OFS_ELO 8'h08
`define HSC_OFS_EHI 8'h0c
`define HSC_OFS_TLO 8'h10
`define HSC_OFS_THI 8'h14
`define HSC_OFS_MCMD 8'h18
`define HSC_OFS_STAT 8'h1c

// ---------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------
`define HSC_CTRL_SWRST 0
`define HSC_CTRL_CNTDIS 1
`define HSC_CTRL_RSTDIS 2
`define HSC_CTRL_CANCEL 3
`define HSC_CTRL_HITCLR 4
`define HSC_CTRL_RST 16'h0000

// ---------------------------------------------------------------
// match command and limits
// ---------------------------------------------------------------
`define HSC_MCMD_IDX_W 9
`define HSC_MCMD_SET 9
`define HSC_OUT_LIMIT 300

`endif

// ===== common/hsc_pkg.sv
// hsc_pkg.sv: types shared by the high-speed counter channel
// assumes nothing beyond a SystemVerilog compiler
package hsc_pkg;

    // count modes, one-hot
    typedef enum logic [3:0] {
        HSC_TWO_PHASE = 4'h1,
        HSC_DECR = 4'h2,
        HSC_UPDN = 4'h4,
        HSC_INC_RST = 4'h8
    } hsc_mode_e;

    // match operation state, one-hot
    typedef enum logic [1:0] {
        HSC_IDLE = 2'h1,
        HSC_ARMED = 2'h2
    } hsc_state_e;

endpackage : hsc_pkg

// ===== design/hsc_channel.sv
// hsc_channel.sv: one high-speed counter channel with APB registers
// assumes pulse and reset inputs already synchronous to pclk
//
// How it works
// - count input edges; on reaching the target act on a chosen output
// - match-set drives the output high, match-clear drives it low
// - modes: two-phase, decremental, up/down inputs, incremental+reset
// - reset input rising edge stops counting and clears the count
// - reset input falling edge lets counting resume
// - control bit 2 disables the reset input
// - control bit 0 holds the counter in software reset
// - control bit 1 disables counting
// - control word settings persist until written again
// - control write may cancel a pending match and clear its flag
// - starting a match operation sets the in-progress flag
// - while in progress, further channel operations are refused
// - odd channel is unusable in two-phase mode, its pin pairs up
// - selected output index must lie below the output limit
// - elapsed value is 32 bits read as two 16-bit words
// - reset input exists only on channels 0 and 2
// - after software reset counting resumes only once bit 0 is zero
`timescale 1ns/100ps
`include "hsc_params.svh"
`default_nettype none

module hsc_channel
    import hsc_pkg::*;
#(
    parameter int CHAN_IDX = 0,
    parameter int NUM_OUT = `HSC_OUT_LIMIT
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pulse inputs
    input wire logic pulse_a,
    input wire logic pulse_b,
    input wire logic reset_in,
    // controlled outputs and status
    output logic [NUM_OUT-1:0] match_out,
    output logic in_progress
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    localparam bit HAS_RST = (CHAN_IDX == 0) || (CHAN_IDX == 2);
    localparam int IW = `HSC_MCMD_IDX_W;
    logic [15:0] ctrl_q;
    hsc_mode_e mode_q;
    hsc_state_e state_q;
    logic [31:0] count_q, count_d, target_q;
    logic [IW-1:0] sel_q;
    logic set_q, hit_q, hold_q;
    logic a_q, b_q, r_q;
    logic [31:0] prdata_q;
    logic acc, wr, busy, known, refuse, ok_wr;
    logic w_ctrl, w_mode, w_elo, w_ehi, w_tlo, w_thi, w_mcmd;
    logic rst_rise, rst_fall, pair_blk, cnt_en, inc, dec;
    logic changed, hit;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    // answer in the first access cycle; read data was captured at setup
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign busy = (state_q == HSC_ARMED);
    assign known = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
    // match commands and elapsed writes are channel operations
    always_comb begin
        refuse = 1'b0;
        if (pwrite && busy && (paddr == `HSC_OFS_MCMD ||
            paddr == `HSC_OFS_ELO || paddr == `HSC_OFS_EHI)) begin
            refuse = 1'b1;
        end
        if (pwrite && paddr == `HSC_OFS_MCMD &&
            pwdata[IW-1:0] >= IW'(NUM_OUT)) begin
            refuse = 1'b1;
        end
        if (pwrite && paddr == `HSC_OFS_MODE &&
            !(pwdata[3:0] inside {HSC_TWO_PHASE, HSC_DECR,
                                 HSC_UPDN, HSC_INC_RST})) begin
            refuse = 1'b1;
        end
    end
    assign ok_wr = wr & known & ~refuse;
    assign w_ctrl = ok_wr && paddr == `HSC_OFS_CTRL;
    assign w_mode = ok_wr && paddr == `HSC_OFS_MODE;
    assign w_elo = ok_wr && paddr == `HSC_OFS_ELO;
    assign w_ehi = ok_wr && paddr == `HSC_OFS_EHI;
    assign w_tlo = ok_wr && paddr == `HSC_OFS_TLO;
    assign w_thi = ok_wr && paddr == `HSC_OFS_THI;
    assign w_mcmd = ok_wr && paddr == `HSC_OFS_MCMD;
    assign pready = acc;
    assign pslverr = acc & (~known | refuse);
    assign prdata = prdata_q;

    // read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `HSC_OFS_MODE: prdata_q <= {28'h000_0000, mode_q};
                `HSC_OFS_ELO: prdata_q <= {16'h0000, count_q[15:0]};
                `HSC_OFS_EHI: prdata_q <= {16'h0000, count_q[31:16]};
                `HSC_OFS_TLO: prdata_q <= {16'h0000, target_q[15:0]};
                `HSC_OFS_THI: prdata_q <= {16'h0000, target_q[31:16]};
                `HSC_OFS_MCMD: prdata_q <= {22'h00_0000, set_q, sel_q};
                `HSC_OFS_STAT: prdata_q <= {30'h0, hit_q, busy};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    // control word is write-only and stays as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `HSC_CTRL_RST;
            mode_q <= HSC_INC_RST;
            target_q <= 32'h0000_0000;
        end else begin
            if (w_ctrl) begin
                ctrl_q <= pwdata[15:0];
            end
            if (w_mode) begin
                mode_q <= hsc_mode_e'(pwdata[3:0]);
            end
            if (w_tlo) begin
                target_q[15:0] <= pwdata[15:0];
            end
            if (w_thi) begin
                target_q[31:16] <= pwdata[15:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // input edges and reset input
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            r_q <= 1'b0;
        end else begin
            a_q <= pulse_a;
            b_q <= pulse_b;
            r_q <= reset_in;
        end
    end

    // reset input absent on channels other than 0 and 2
    assign rst_rise = HAS_RST & reset_in & ~r_q &
                      ~ctrl_q[`HSC_CTRL_RSTDIS];
    assign rst_fall = HAS_RST & ~reset_in & r_q &
                      ~ctrl_q[`HSC_CTRL_RSTDIS];

    // hold keeps counting off between the two reset-input edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 1'b0;
        end else if (rst_rise) begin
            hold_q <= 1'b1;
        end else if (rst_fall) begin
            hold_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // count step per mode
    // ---------------------------------------------------------------
    // an odd channel lends its pin to the even one in two-phase mode
    assign pair_blk = (CHAN_IDX % 2 == 1) && (mode_q == HSC_TWO_PHASE);
    assign cnt_en = ~ctrl_q[`HSC_CTRL_SWRST] &
                    ~ctrl_q[`HSC_CTRL_CNTDIS] & ~hold_q & ~pair_blk;
    always_comb begin
        inc = 1'b0;
        dec = 1'b0;
        case (mode_q)
            HSC_TWO_PHASE: begin
                // gray step forward when A leads, backward when B leads
                case ({a_q, b_q, pulse_a, pulse_b})
                    4'h2, 4'hb, 4'hd, 4'h4: inc = 1'b1;
                    4'h1, 4'h7, 4'he, 4'h8: dec = 1'b1;
                    default: ;
                endcase
            end
            HSC_DECR: dec = pulse_a & ~a_q;
            HSC_UPDN: begin
                // both edges together cancel out
                inc = pulse_a & ~a_q & ~(pulse_b & ~b_q);
                dec = pulse_b & ~b_q & ~(pulse_a & ~a_q);
            end
            HSC_INC_RST: inc = pulse_a & ~a_q;
            default: ;
        endcase
    end

    // ---------------------------------------------------------------
    // elapsed value
    // ---------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        if (ctrl_q[`HSC_CTRL_SWRST] || rst_rise) begin
            count_d = 32'h0000_0000;
        end else if (w_elo) begin
            count_d = {count_q[31:16], pwdata[15:0]};
        end else if (w_ehi) begin
            count_d = {pwdata[15:0], count_q[15:0]};
        end else if (cnt_en && inc) begin
            count_d = count_q + 32'h0000_0001;
        end else if (cnt_en && dec) begin
            count_d = count_q - 32'h0000_0001;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 32'h0000_0000;
        end else begin
            count_q <= count_d;
        end
    end

    // ---------------------------------------------------------------
    // match operation
    // ---------------------------------------------------------------
    // compare the new value only when it moves, so a parked count
    // equal to the target does not fire a freshly armed match
    assign changed = (count_d != count_q);
    assign hit = busy && changed && (count_d == target_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= HSC_IDLE;
            sel_q <= '0;
            set_q <= 1'b0;
        end else begin
            case (state_q)
                HSC_IDLE: begin
                    if (w_mcmd) begin
                        state_q <= HSC_ARMED;
                        sel_q <= pwdata[IW-1:0];
                        set_q <= pwdata[`HSC_MCMD_SET];
                    end
                end
                HSC_ARMED: begin
                    if (hit || (w_ctrl && pwdata[`HSC_CTRL_CANCEL])) begin
                        state_q <= HSC_IDLE;
                    end
                end
                default: state_q <= HSC_IDLE;
            endcase
        end
    end
    assign in_progress = state_q[1];

    // outputs move only on a match; elsewhere they keep their level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_out <= '0;
        end else if (hit) begin
            match_out[sel_q] <= set_q;
        end
    end

    // sticky match flag; a new match beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_q <= 1'b0;
        end else if (hit) begin
            hit_q <= 1'b1;
        end else if (w_ctrl && pwdata[`HSC_CTRL_HITCLR]) begin
            hit_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    AST_SET_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        hit && set_q |=> match_out[$past(sel_q)] && !in_progress)
        else $error("match-set did not drive output high");
    AST_CLR_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        hit && !set_q |=> !match_out[$past(sel_q)])
        else $error("match-clear did not drive output low");
    AST_RST_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        rst_rise |=> count_q == 32'h0000_0000 && hold_q)
        else $error("reset input rise did not clear and stop");
    AST_RST_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        hold_q && rst_fall |=> !hold_q ##0 (cnt_en == (~pair_blk &
        ~ctrl_q[`HSC_CTRL_SWRST] & ~ctrl_q[`HSC_CTRL_CNTDIS])))
        else $error("reset input fall did not re-enable");
    AST_RST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[`HSC_CTRL_RSTDIS] && !hold_q |=> !hold_q)
        else $error("disabled reset input still acted");
    AST_SWRST: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[`HSC_CTRL_SWRST] |=> count_q == 32'h0000_0000)
        else $error("software reset left a nonzero count");
    AST_CNT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[`HSC_CTRL_CNTDIS] && !ctrl_q[`HSC_CTRL_SWRST] && !w_elo &&
        !w_ehi && !rst_rise |=> count_q == $past(count_q))
        else $error("count moved while disabled");
    AST_BUSY_SET: assert property (@(posedge pclk) disable iff (!presetn)
        w_mcmd |=> in_progress ##0 sel_q == $past(pwdata[IW-1:0]))
        else $error("match start did not set in-progress");
    AST_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
        wr && in_progress && paddr == `HSC_OFS_MCMD
        |-> pslverr ##1 sel_q == $past(sel_q))
        else $error("operation accepted while in progress");
    AST_QUAD_UP: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == HSC_TWO_PHASE && cnt_en && !a_q && !b_q && pulse_a &&
        !pulse_b && !w_elo && !w_ehi && !rst_rise
        |=> count_q == $past(count_q) + 32'h0000_0001)
        else $error("quadrature step A-leads did not count up");

endmodule : hsc_channel

`default_nettype wire

// ===== test/hsc_pulse_src.sv
// hsc_pulse_src.sv: pulse source model driving the counter pulse lines
// assumes one step request at a time, spaced at least four cycles apart
`timescale 1ns/100ps
`default_nettype none

module hsc_pulse_src (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // step request from the bench
    input wire logic step_req,
    input wire logic up,
    input wire logic quad,
    // pulse lines toward the channel
    output logic pulse_a,
    output logic pulse_b
);
    logic [1:0] ph_q;
    logic sp_a_q;
    logic sp_b_q;
    logic hold_q;

    // quadrature walk 00,10,11,01 forward; one transition per step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= 2'h0;
        end else if (step_req && quad) begin
            ph_q <= up ? {~ph_q[0], ph_q[1]} : {ph_q[0], ~ph_q[1]};
        end
    end

    // single-phase pulse held high two cycles so each level is half a period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_a_q <= 1'b0;
            sp_b_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (step_req && !quad) begin
            sp_a_q <= up;
            sp_b_q <= !up;
            hold_q <= 1'b1;
        end else if (hold_q) begin
            hold_q <= 1'b0;
        end else begin
            sp_a_q <= 1'b0;
            sp_b_q <= 1'b0;
        end
    end

    // a quad level is held a whole step spacing, a quarter period or more;
    // these lines serve counting only and never carry a home signal
    assign pulse_a = quad ? ph_q[1] : sp_a_q;
    assign pulse_b = quad ? ph_q[0] : sp_b_q;
endmodule : hsc_pulse_src

`default_nettype wire

// ===== test/testbench.sv
// testbench.sv: self-checking bench for one counter channel, channel 0
// assumes the pulse source model and the channel share one 250 MHz clock
`timescale 1ns/100ps
`include "hsc_params.svh"
`default_nettype none

module testbench
    import hsc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, exp_cnt;
    logic pulse_a, pulse_b, reset_in, in_progress, step_req, up, quad;
    logic cnt_on, busy;
    logic [299:0] match_out;
    logic [3:0] mode;
    logic [8:0] idx;
    int errors, n_tests, pos, n, k;

    hsc_channel #(.CHAN_IDX(0), .NUM_OUT(`HSC_OUT_LIMIT)) hsc_channel_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulse_a(pulse_a),
        .pulse_b(pulse_b), .reset_in(reset_in), .match_out(match_out),
        .in_progress(in_progress));

    hsc_pulse_src hsc_pulse_src_i (
        .pclk(pclk), .presetn(presetn), .step_req(step_req), .up(up),
        .quad(quad), .pulse_a(pulse_a), .pulse_b(pulse_b));

    // ---------------------------------------------------------------
    // checking and bus tasks
    // ---------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; an idle cycle follows so requests never collide
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 20) begin
            t++;
            @(posedge pclk);
        end
        if (t == 20) begin
            errors++;
            end_sim();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic e);
        logic [31:0] r;
        logic x;
        apb(1'b1, a, d, r, x);
        chk({31'h0, x}, {31'h0, e});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] v,
            input logic e);
        logic [31:0] r;
        logic x;
        apb(1'b0, a, 32'h0, r, x);
        chk({31'h0, x}, {31'h0, e});
        if (!e) chk(r, v);
    endtask : rd

    // elapsed value read back as two halves
    task automatic cnt_chk();
        logic [31:0] lo, hi;
        logic x;
        apb(1'b0, `HSC_OFS_ELO, 32'h0, lo, x);
        apb(1'b0, `HSC_OFS_EHI, 32'h0, hi, x);
        chk({hi[15:0], lo[15:0]}, exp_cnt);
    endtask : cnt_chk

    // ---------------------------------------------------------------
    // expectation and stimulus helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] c,
            input logic u);
        if (mode == HSC_DECR) return c - 32'h1;
        if (mode == HSC_INC_RST) return c + 32'h1;
        return u ? c + 32'h1 : c - 32'h1;
    endfunction : nxt

    task automatic cnt_step(input logic u);
        step_req <= 1'b1;
        up <= u;
        quad <= (mode == HSC_TWO_PHASE);
        @(posedge pclk);
        step_req <= 1'b0;
        repeat (3) @(posedge pclk);
        if (cnt_on) exp_cnt = nxt(exp_cnt, u);
        if (mode == HSC_TWO_PHASE) pos = u ? pos + 1 : pos - 1;
    endtask : cnt_step

    task automatic set_rst(input logic v);
        reset_in <= v;
        repeat (3) @(posedge pclk);
    endtask : set_rst

    task automatic set_mode(input logic [3:0] m);
        mode = m;
        wr(`HSC_OFS_MODE, {28'h0, m}, 1'b0);
    endtask : set_mode

    // target three counts ahead, then arm set or clear of one output
    task automatic arm(input logic s);
        logic [31:0] t;
        t = exp_cnt + 32'h3;
        wr(`HSC_OFS_TLO, {16'h0, t[15:0]}, 1'b0);
        wr(`HSC_OFS_THI, {16'h0, t[31:16]}, 1'b0);
        wr(`HSC_OFS_MCMD, {22'h0, s, idx}, 1'b0);
    endtask : arm

    // ---------------------------------------------------------------
    // clock, watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        repeat (100000) @(posedge pclk);
        errors++;
        end_sim();
    end

    initial begin
        {presetn, psel, penable, pwrite, reset_in, step_req, up} = '0;
        {paddr, pwdata, quad, pos, errors, n_tests, exp_cnt} = '0;
        mode = HSC_INC_RST;
        cnt_on = 1'b1;
        void'($urandom(32'h4fa3));
        idx = 9'($urandom_range(0, 299));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`HSC_OFS_MODE, 32'h8, 1'b0);
        rd(`HSC_OFS_STAT, 32'h0, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        rd(8'h02, 32'h0, 1'b1);
        n = $urandom_range(3, 9);
        repeat (n) cnt_step(1'b1);
        cnt_chk();
        set_rst(1'b1);
        exp_cnt = 32'h0;
        cnt_on = 1'b0;
        cnt_step(1'b1);
        cnt_chk();
        set_rst(1'b0);
        cnt_on = 1'b1;
        cnt_step(1'b1);
        cnt_chk();
        wr(`HSC_OFS_CTRL, 32'h4, 1'b0);
        set_rst(1'b1);
        cnt_step(1'b1);
        cnt_chk();
        set_rst(1'b0);
        wr(`HSC_OFS_CTRL, 32'h2, 1'b0);
        cnt_on = 1'b0;
        repeat (n) cnt_step(1'b1);
        cnt_chk();
        wr(`HSC_OFS_CTRL, 32'h1, 1'b0);
        exp_cnt = 32'h0;
        cnt_step(1'b1);
        cnt_chk();
        wr(`HSC_OFS_CTRL, 32'h0, 1'b0);
        cnt_on = 1'b1;
        cnt_step(1'b1);
        cnt_chk();
        // decrement below zero so the upper half wraps as well
        set_mode(HSC_DECR);
        repeat (n) cnt_step(1'b1);
        cnt_chk();
        set_mode(HSC_UPDN);
        repeat (n) cnt_step(1'($urandom_range(0, 1)));
        cnt_chk();
        set_mode(HSC_TWO_PHASE);
        repeat (2 * n) cnt_step(1'($urandom_range(0, 1)));
        while ((pos & 3) != 0) cnt_step(1'b1);
        cnt_chk();
        wr(`HSC_OFS_MODE, 32'h3, 1'b1);
        set_mode(HSC_INC_RST);
        wr(`HSC_OFS_MCMD, {22'h0, 1'b1, 9'd300}, 1'b1);
        // set then clear the same output; refusals while armed
        for (k = 0; k < 2; k++) begin
            arm(k == 0);
            busy = in_progress;
            chk({31'h0, busy}, 32'h1);
            wr(`HSC_OFS_MCMD, {22'h0, 1'b1, idx}, 1'b1);
            wr(`HSC_OFS_ELO, 32'h0, 1'b1);
            cnt_step(1'b1);
            cnt_step(1'b1);
            chk({31'h0, match_out[idx]}, 32'(k));
            cnt_step(1'b1);
            chk({31'h0, match_out[idx]}, 32'(k == 0));
            chk({31'h0, |(match_out & ~(300'h1 << idx))}, 32'h0);
            chk({31'h0, in_progress}, 32'h0);
            rd(`HSC_OFS_STAT, 32'h2, 1'b0);
            wr(`HSC_OFS_CTRL, 32'h10, 1'b0);
            rd(`HSC_OFS_STAT, 32'h0, 1'b0);
        end
        arm(1'b1);
        wr(`HSC_OFS_CTRL, 32'h8, 1'b0);
        chk({31'h0, in_progress}, 32'h0);
        repeat (3) cnt_step(1'b1);
        chk({31'h0, match_out[idx]}, 32'h0);
        end_sim();
    end
endmodule : testbench

`default_nettype wire
